// ==== shared/dcl_pkg.sv ====
/*
 Package for the display idle-depth limiter: depth codes, resolution classes,
 register map and config structs. Assumes a single 100 MHz clock domain.
*/
package dcl_pkg;

	// Package idle depth codes, larger is deeper
	localparam logic [3:0] DCL_PC0 = 4'h0;
	localparam logic [3:0] DCL_PC2 = 4'h2;
	localparam logic [3:0] DCL_PC6 = 4'h6;
	localparam logic [3:0] DCL_PC7 = 4'h7;
	localparam logic [3:0] DCL_PC10 = 4'hA;

	// Resolution classes, ordered by size
	localparam logic [3:0] DCL_RES_800X600 = 4'h0;
	localparam logic [3:0] DCL_RES_1024X768 = 4'h1;
	localparam logic [3:0] DCL_RES_1280X1024 = 4'h2;
	localparam logic [3:0] DCL_RES_1920X1080 = 4'h3;
	localparam logic [3:0] DCL_RES_1920X1200 = 4'h4;
	localparam logic [3:0] DCL_RES_1920X1440 = 4'h5;
	localparam logic [3:0] DCL_RES_2048X1536 = 4'h6;
	localparam logic [3:0] DCL_RES_2560X1600 = 4'h7;
	localparam logic [3:0] DCL_RES_2560X1920 = 4'h8;

	// Register byte offsets
	localparam logic [11:0] DCL_DISP_CFG_OFS = 12'h000;
	localparam logic [11:0] DCL_LIMIT_CFG_OFS = 12'h004;
	localparam logic [11:0] DCL_STATUS_OFS = 12'h008;

	// Field positions of display config register
	localparam int DCL_F_ON = 0;
	localparam int DCL_F_MULTI = 1;
	localparam int DCL_F_SCALED = 2;
	localparam int DCL_F_SELF_REFRESH = 3;
	localparam int DCL_F_NATIVE = 4;
	localparam int DCL_F_SHOWN = 8;
	localparam int DCL_F_BLEND = 12;

	// Reset values
	localparam logic [31:0] DCL_DISP_CFG_RST = 32'h0000_0000;
	localparam logic [31:0] DCL_LIMIT_CFG_RST = 32'h0000_AAAA;

	typedef struct packed {
		logic on;
		logic multi;
		logic scaled;
		logic panel_self_refresh;
		logic [3:0] native_res;
		logic [3:0] shown_res;
		logic blend_deep;
	} dcl_disp_t;

	typedef struct packed {
		logic [3:0] workload;
		logic [3:0] idle;
		logic [3:0] power_src;
		logic [3:0] latency;
	} dcl_limits_t;

endpackage

// ==== src/dcl_limiter.sv ====
/*
 Display idle-depth limiter: an APB slave holding the display configuration
 and software limits, producing the permitted package idle depth.
 Assumes APB master in clk_i domain and external limits synchronous to clk_i.
*/
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps
// Function
// RQ1 - Cap idle depth from display on, count, scaling and self refresh.
// RQ2 - Display cap is one constraint among device, interrupt and processor limits.
// RQ3 - Single display: PC7 to 1920x1200, PC6 to 2560x1600, else PC2.
// RQ4 - Multiple displays: PC7 at 800x600, PC6 to 1280x1024, else PC2.
// RQ5 - Multiple displays use highest native resolution; self refresh ignored.
// RQ6 - Self refresh with one native display allows PC7 at any resolution.
// RQ7 - Self refresh with multiple displays uses the multiple-display cap.
// RQ8 - Scaled mode ignores self refresh; cap lies between native and shown caps.
// RQ9 - Workload, idleness and power source may further restrict depth.
// RQ10 - Output depth is the shallowest of all active constraints.
// RQ11 - All displays off imposes no display restriction.
module dcl_limiter
	import dcl_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Other latency constraints
	input wire logic [3:0] cpu_limit_i,
	input wire logic [3:0] irq_limit_i,
	input wire logic [3:0] dev_limit_i,
	// Result to the package power-state controller
	output logic [3:0] depth_limit_o,
	output logic [3:0] disp_cap_o
);

	// ----------------------------------------
	// Cap lookup functions
	// ----------------------------------------
	function automatic logic [3:0] single_cap(input logic [3:0] res);
		if (res <= DCL_RES_1920X1200) begin
			single_cap = DCL_PC7; // RQ3
		end else if (res <= DCL_RES_2560X1600) begin
			single_cap = DCL_PC6; // RQ3
		end else begin
			single_cap = DCL_PC2; // RQ3
		end
	endfunction

	function automatic logic [3:0] multi_cap(input logic [3:0] res);
		if (res == DCL_RES_800X600) begin
			multi_cap = DCL_PC7; // RQ4
		end else if (res <= DCL_RES_1280X1024) begin
			multi_cap = DCL_PC6; // RQ4
		end else begin
			multi_cap = DCL_PC2; // RQ4
		end
	endfunction

	function automatic logic [3:0] min4(input logic [3:0] a, input logic [3:0] b);
		min4 = (a < b) ? a : b;
	endfunction

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [31:0] disp_cfg_r, disp_cfg_nxt;
	logic [31:0] limit_cfg_r, limit_cfg_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;
	logic [3:0] depth_r, depth_nxt;
	logic [3:0] cap_r, cap_nxt;
	dcl_disp_t disp;
	dcl_limits_t lim;
	logic acc;
	logic hit;

	assign disp.on = disp_cfg_r[DCL_F_ON];
	assign disp.multi = disp_cfg_r[DCL_F_MULTI];
	assign disp.scaled = disp_cfg_r[DCL_F_SCALED];
	assign disp.panel_self_refresh = disp_cfg_r[DCL_F_SELF_REFRESH];
	assign disp.native_res = disp_cfg_r[DCL_F_NATIVE +: 4];
	assign disp.shown_res = disp_cfg_r[DCL_F_SHOWN +: 4];
	assign disp.blend_deep = disp_cfg_r[DCL_F_BLEND];
	assign lim = limit_cfg_r[15:0];

	// ----------------------------------------
	// APB slave, one wait state per access
	// ----------------------------------------
	assign acc = psel_i && penable_i && !pready_r;
	always_comb begin
		disp_cfg_nxt = disp_cfg_r;
		limit_cfg_nxt = limit_cfg_r;
		prdata_nxt = prdata_r;
		pready_nxt = acc;
		pslverr_nxt = 1'b0;
		hit = (paddr_i == DCL_DISP_CFG_OFS) || (paddr_i == DCL_LIMIT_CFG_OFS) ||
			(paddr_i == DCL_STATUS_OFS);
		if (acc) begin
			pslverr_nxt = !hit;
			prdata_nxt = 32'h0000_0000;
			if (pwrite_i) begin
				if (paddr_i == DCL_DISP_CFG_OFS) begin
					disp_cfg_nxt = pwdata_i & 32'h0000_1FFF;
				end
				if (paddr_i == DCL_LIMIT_CFG_OFS) begin
					limit_cfg_nxt = pwdata_i & 32'h0000_FFFF;
				end
			end else begin
				unique case (paddr_i)
					DCL_DISP_CFG_OFS: prdata_nxt = disp_cfg_r;
					DCL_LIMIT_CFG_OFS: prdata_nxt = limit_cfg_r;
					DCL_STATUS_OFS: prdata_nxt = {24'h00_0000, cap_r, depth_r};
					default: prdata_nxt = 32'h0000_0000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Depth computation
	// ----------------------------------------
	logic [3:0] gov_res;
	logic [3:0] c_nat, c_shown;
	logic [3:0] other;
	always_comb begin
		gov_res = disp.native_res; // RQ5
		c_nat = disp.multi ? multi_cap(disp.native_res) : single_cap(disp.native_res);
		c_shown = disp.multi ? multi_cap(disp.shown_res) : single_cap(disp.shown_res);
		if (!disp.on) begin
			cap_nxt = DCL_PC10; // RQ11
		end else if (disp.multi) begin
			cap_nxt = multi_cap(gov_res); // RQ4 RQ5 RQ7
		end else if (disp.scaled) begin
			// Self refresh dropped; pick a bound of the native/shown interval
			if (disp.blend_deep) begin
				cap_nxt = (c_nat > c_shown) ? c_nat : c_shown; // RQ8
			end else begin
				cap_nxt = min4(c_nat, c_shown); // RQ8
			end
		end else if (disp.panel_self_refresh) begin
			cap_nxt = DCL_PC7; // RQ6
		end else begin
			cap_nxt = single_cap(gov_res); // RQ1 RQ3
		end
		other = min4(min4(cpu_limit_i, irq_limit_i), dev_limit_i); // RQ2
		other = min4(other, min4(min4(lim.workload, lim.idle), lim.power_src)); // RQ9
		other = min4(other, lim.latency); // RQ2
		depth_nxt = min4(cap_r, other); // RQ10
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			disp_cfg_r <= DCL_DISP_CFG_RST;
			limit_cfg_r <= DCL_LIMIT_CFG_RST;
			prdata_r <= 32'h0000_0000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			depth_r <= DCL_PC0;
			cap_r <= DCL_PC10;
		end else begin
			disp_cfg_r <= disp_cfg_nxt;
			limit_cfg_r <= limit_cfg_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			depth_r <= depth_nxt;
			cap_r <= cap_nxt;
		end
	end

	assign prdata_o = prdata_r;
	assign pready_o = pready_r;
	assign pslverr_o = pslverr_r;
	assign depth_limit_o = depth_r;
	assign disp_cap_o = cap_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Depth lags the cap by one cycle, so compare with the previous cap
	a_depth_not_deeper: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ10
		!$past(sys_rst_i) |-> depth_r <= $past(cap_r))
		else $error("depth deeper than display cap");
	a_off_no_cap: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ11
		$past(!disp.on) && !$past(sys_rst_i) |-> cap_r == DCL_PC10)
		else $error("display off still capped");
	a_psr_single_pc7: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ6
		$past(disp.on && disp.panel_self_refresh && !disp.multi && !disp.scaled)
		&& !$past(sys_rst_i) |-> cap_r == DCL_PC7) else $error("self refresh cap wrong");
	a_multi_big_pc2: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ4
		$past(disp.on && disp.multi && disp.native_res >= DCL_RES_1920X1080)
		&& !$past(sys_rst_i) |-> cap_r == DCL_PC2) else $error("multi cap wrong");
	a_multi_small_pc7: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ7
		$past(disp.on && disp.multi && disp.native_res == DCL_RES_800X600)
		&& !$past(sys_rst_i) |-> cap_r == DCL_PC7) else $error("multi 800x600 wrong");
	a_single_mid_pc6: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ3
		$past(disp.on && !disp.multi && !disp.scaled && !disp.panel_self_refresh &&
		disp.native_res == DCL_RES_2048X1536) && !$past(sys_rst_i) |-> cap_r == DCL_PC6)
		else $error("single mid cap wrong");
	a_single_small_pc7: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ3
		$past(disp.on && !disp.multi && !disp.scaled && !disp.panel_self_refresh &&
		disp.native_res <= DCL_RES_1920X1200) && !$past(sys_rst_i) |-> cap_r == DCL_PC7)
		else $error("single small cap wrong");
	a_single_big_pc2: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ3
		$past(disp.on && !disp.multi && !disp.scaled && !disp.panel_self_refresh &&
		disp.native_res > DCL_RES_2560X1600) && !$past(sys_rst_i) |-> cap_r == DCL_PC2)
		else $error("single big cap wrong");
	a_scaled_range: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ8
		$past(disp.on && !disp.multi && disp.scaled) && !$past(sys_rst_i) |->
		cap_r == $past(single_cap(disp.native_res)) ||
		cap_r == $past(single_cap(disp.shown_res)))
		else $error("scaled cap out of range");
	a_other_limits: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ2
		!$past(sys_rst_i) |-> depth_r <= $past(cpu_limit_i) && depth_r <= $past(lim.power_src))
		else $error("other limit ignored");
	a_apb_one_cycle: assert property (@(posedge clk_i) disable iff (sys_rst_i) // APB timing, decided for this implementation
		psel_i && penable_i && !pready_r |=> pready_r ##1 !pready_r)
		else $error("apb ready timing");

endmodule

// ==== verif/dcl_pwr_model.sv ====
/*
 Model of the package power-state controller side: holds the core,
 interrupt and device limits. Assumes the bench sets requests by NBA.
*/
`timescale 1ns/1ps
module dcl_pwr_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Requested limits {cpu, irq, dev}
	input wire logic [11:0] lim_req_i,
	// Limits to the limiter
	output logic [3:0] cpu_limit_o,
	output logic [3:0] irq_limit_o,
	output logic [3:0] dev_limit_o
);
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			{cpu_limit_o, irq_limit_o, dev_limit_o} <= 12'h0AAA;
		end else begin
			{cpu_limit_o, irq_limit_o, dev_limit_o} <= lim_req_i;
		end
	end
endmodule

// ==== verif/tb.sv ====
/*
 Testbench of the display idle-depth limiter: table of display
 configurations, then reset, limit and bus-error cases.
 Assumes the one-wait-state APB slave of the design.
*/
`timescale 1ns/1ps
module tb;
	import dcl_pkg::*;
	logic clk_i = 0, sys_rst_i = 1, psel = 0, penable = 0, pwrite = 0, err;
	logic [11:0] paddr = 0, lim_req = 12'h0AAA;
	logic [31:0] pwdata = 0, prdata_o, r;
	logic pready_o, pslverr_o;
	logic [3:0] cpu_l, irq_l, dev_l, depth_limit_o, disp_cap_o;
	int n_mismatch = 0, num_checks = 0;
	// Rows: {config word, expected cap}
	localparam logic [19:0] ROWS [14] = '{20'h0000_A, 20'h0441_7, 20'h0551_6,
		20'h0771_6, 20'h0881_2, 20'h0003_7, 20'h0113_6, 20'h0223_6, 20'h0333_2,
		20'h0889_7, 20'h011B_6, 20'h077B_2, 20'h038D_2, 20'h1385_7};
	dcl_limiter u_dcl_limiter (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.cpu_limit_i(cpu_l), .irq_limit_i(irq_l), .dev_limit_i(dev_l),
		.depth_limit_o(depth_limit_o), .disp_cap_o(disp_cap_o));
	dcl_pwr_model u_dcl_pwr_model (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.lim_req_i(lim_req), .cpu_limit_o(cpu_l), .irq_limit_o(irq_l),
		.dev_limit_o(dev_l));
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge clk_i);
		penable <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 20);
		if (n >= 20) chk(0, 1);
		r = prdata_o;
		err = pslverr_o;
		{psel, penable} <= 2'b00;
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#100000;
		n_mismatch++;
		finish_test;
	end
	initial begin
		repeat (6) @(posedge clk_i);
		chk({depth_limit_o, disp_cap_o}, {DCL_PC0, DCL_PC10});
		sys_rst_i <= 0;
		apb(0, DCL_DISP_CFG_OFS, 0);
		chk(r, DCL_DISP_CFG_RST);
		apb(0, DCL_LIMIT_CFG_OFS, 0);
		chk(r, DCL_LIMIT_CFG_RST);
		foreach (ROWS[i]) begin
			apb(1, DCL_DISP_CFG_OFS, {16'h0000, ROWS[i][19:4]});
			repeat (2) @(posedge clk_i);
			chk(disp_cap_o, ROWS[i][3:0]);
			apb(0, DCL_STATUS_OFS, 0);
			chk(r, {24'h0, ROWS[i][3:0], ROWS[i][3:0]});
		end
		apb(1, DCL_DISP_CFG_OFS, 32'h0000_0441);
		for (int k = 0; k < 3; k++) begin
			lim_req <= 12'h0AAA & ~(12'h0C00 >> 4 * k);
			repeat (4) @(posedge clk_i);
			chk(depth_limit_o, DCL_PC2);
		end
		lim_req <= 12'h06AA;
		repeat (4) @(posedge clk_i);
		chk(depth_limit_o, DCL_PC6);
		lim_req <= 12'h0AAA;
		for (int k = 0; k < 4; k++) begin
			apb(1, DCL_LIMIT_CFG_OFS, 32'h0000_AAAA & ~(32'h0000_0008 << 4 * k));
			repeat (2) @(posedge clk_i);
			chk(depth_limit_o, DCL_PC2);
		end
		apb(1, DCL_LIMIT_CFG_OFS, DCL_LIMIT_CFG_RST);
		apb(1, 12'h00C, 32'h0000_0000);
		chk(err, 1);
		apb(0, 12'h00C, 0);
		chk(err, 1);
		chk(r, 32'h0000_0000);
		apb(0, DCL_STATUS_OFS, 0);
		chk(r, 32'h0000_0077);
		// Mid-run reset brings back reset values
		apb(1, DCL_LIMIT_CFG_OFS, 32'h0000_6666);
		apb(1, DCL_DISP_CFG_OFS, 32'h0000_0881);
		repeat (2) @(posedge clk_i);
		chk(depth_limit_o, DCL_PC2);
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk({pready_o, depth_limit_o, disp_cap_o}, {1'b0, DCL_PC0, DCL_PC10});
		sys_rst_i <= 1'b0;
		apb(0, DCL_DISP_CFG_OFS, 0);
		chk(r, DCL_DISP_CFG_RST);
		apb(0, DCL_LIMIT_CFG_OFS, 0);
		chk(r, DCL_LIMIT_CFG_RST);
		apb(0, DCL_STATUS_OFS, 0);
		chk(r, {24'h00_0000, DCL_PC10, DCL_PC10});
		finish_test;
	end
endmodule
